/* File: burst_restart_pkg.sv */
// Summary of operation
// - Burst entry timer stays cleared normally, counts while feedback is below 1.35V.
// - Timer reaching 20ms with feedback still low switches into burst mode.
// - Burst entry sets the burst flag and turns internal bias off.
// - In burst, feedback above 3.5V turns bias on and resumes switching.
// - Reduced current-limit select is held high throughout burst mode.
// - In burst with flag set, feedback down at 3.0V turns bias off.
// - Feedback above 4.0V in burst leaves burst and restores full current limit.
// - Overload and open loop use extended blanking; other faults restart directly.
// - Restart stops switching; cell on at turn-off level, off at turn-on level.
// - After start-up the fault is checked again: restart or resume normal.
// - Feedback above 4.0V in normal operation counts 20ms, then releases pin clamp.
// - Overload blanking done and pin above 4.0V restarts after 30us.
// - During soft start, supply above 20.5V with feedback above 4.0V restarts.
// - Supply above 25.5V for 120us restarts; check disabled in burst.
// - Junction temperature above 130 degrees C forces auto-restart.
// - Pin below 0.33V stops gating, restarts if persistent, ignored 1ms at start.
// - Supply undervoltage turns off and enables startup cell as auto-restart.
// - Burst entry uses only internal blanking; overload also waits on pin charge.
package burst_restart_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int MS_DIV = 1000;
  localparam int US_DIV = 1_000_000;
  // Times as specified, rounded up to whole cycles
  localparam int BLANK_MS = 20;
  localparam int SPIKE_US = 30;
  localparam int OVP_US = 120;
  localparam int IGNORE_MS = 1;
  localparam int BLANK_CYC = (BLANK_MS * CLK_HZ + MS_DIV - 1) / MS_DIV;
  localparam int SPIKE_CYC = (SPIKE_US * CLK_HZ + US_DIV - 1) / US_DIV;
  localparam int OVP_CYC = (OVP_US * CLK_HZ + US_DIV - 1) / US_DIV;
  localparam int IGNORE_CYC = (IGNORE_MS * CLK_HZ + MS_DIV - 1) / MS_DIV;
  // Timer slots
  localparam int N_TIMERS = 6;
  localparam int T_BURST = 0;
  localparam int T_LOAD = 1;
  localparam int T_SPIKE = 2;
  localparam int T_OVP = 3;
  localparam int T_IGN = 4;
  localparam int T_EXT = 5;
  // Comparator vector positions
  localparam int N_CMP = 11;
  localparam int C_FB_HIGH = 0;
  localparam int C_FB_LOW = 1;
  localparam int C_BURST_UP = 2;
  localparam int C_BURST_LO = 3;
  localparam int C_SUP_OVER = 4;
  localparam int C_SUP_SS = 5;
  localparam int C_SUP_ON = 6;
  localparam int C_SUP_UV = 7;
  localparam int C_PIN_HIGH = 8;
  localparam int C_PIN_LOW = 9;
  localparam int C_THERMAL = 10;
  typedef enum logic [4:0] {
    ST_NORMAL = 5'h01,
    ST_BURST = 5'h02,
    ST_RESTART = 5'h04,
    ST_CHARGE = 5'h08,
    ST_SOFT = 5'h10
  } state_t;
endpackage : burst_restart_pkg

/* File: blank_timer_if.sv */
`timescale 1ns/1ps
interface blank_timer_if;
  logic run;
  logic done;
  modport timer (input run, output done);
  modport ctrl (output run, input done);
endinterface : blank_timer_if

/* File: blank_timer.sv */
`timescale 1ns/1ps
module blank_timer #(
  parameter int unsigned LIMIT = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Run and done
  blank_timer_if.timer tif
);
  logic [31:0] count;

  // Cleared whenever run drops, so a glitch restarts the whole window
  always_ff @(posedge clk) begin
    if (!rst_n || !tif.run) begin
      count <= 32'h0;
    end else if (count != LIMIT) begin
      count <= count + 32'h1;
    end
  end

  assign tif.done = (count == LIMIT);

  // Done may only rise after run was high on the previous edge
  done_window_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(tif.done) |-> $past(tif.run))
    else $error("timer done without run");
endmodule : blank_timer

/* File: burst_restart_ctrl.sv */
`timescale 1ns/1ps
module burst_restart_ctrl #(
  parameter int BLANK_CYCLES = burst_restart_pkg::BLANK_CYC,
  parameter int IGNORE_CYCLES = burst_restart_pkg::IGNORE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Feedback comparators
  input wire logic feedback_high_comparator,
  input wire logic feedback_low_comparator,
  input wire logic burst_upper_comparator,
  input wire logic burst_lower_comparator,
  // Supply comparators
  input wire logic supply_over_comparator,
  input wire logic supply_soft_over,
  input wire logic supply_turn_on,
  input wire logic supply_under,
  // Blanking pin and thermal comparators
  input wire logic pin_high,
  input wire logic pin_low,
  input wire logic thermal_over,
  // Soft-start block
  input wire logic soft_start_done,
  // Control outputs
  output logic bias_enable,
  output logic reduced_limit_select,
  output logic gate_enable,
  output logic startup_cell_on,
  output logic pin_clamp_switch,
  // Status outputs
  output logic burst_flag,
  output logic in_soft_start,
  output logic in_restart
);
  localparam int LIMITS [burst_restart_pkg::N_TIMERS] = '{
    BLANK_CYCLES,
    BLANK_CYCLES,
    burst_restart_pkg::SPIKE_CYC,
    burst_restart_pkg::OVP_CYC,
    IGNORE_CYCLES,
    burst_restart_pkg::SPIKE_CYC
  };

  burst_restart_pkg::state_t state;
  burst_restart_pkg::state_t next_state;
  logic [burst_restart_pkg::N_CMP-1:0] cmp_raw;
  logic [burst_restart_pkg::N_CMP-1:0] cmp_meta;
  logic [burst_restart_pkg::N_CMP-1:0] cmp;
  logic [burst_restart_pkg::N_TIMERS-1:0] trun;
  logic [burst_restart_pkg::N_TIMERS-1:0] tdone;
  logic fb_high;
  logic fb_low;
  logic burst_up;
  logic burst_lo;
  logic sup_over;
  logic sup_ss;
  logic sup_on;
  logic sup_uv;
  logic ba_high;
  logic ba_low;
  logic hot;
  logic ext_active;
  logic restart_and_gate;
  logic soft_ovp;
  logic restart_req;
  logic fault_now;
  logic burst_bias_gate;
  logic next_bias;
  logic reduced_limit_gate;

  // States in which the power stage may switch
  function automatic logic is_operating(input burst_restart_pkg::state_t s);
    return (s == burst_restart_pkg::ST_NORMAL) || (s == burst_restart_pkg::ST_BURST)
      || (s == burst_restart_pkg::ST_SOFT);
  endfunction : is_operating

  assign cmp_raw = {thermal_over, pin_low, pin_high, supply_under, supply_turn_on,
    supply_soft_over, supply_over_comparator, burst_lower_comparator,
    burst_upper_comparator, feedback_low_comparator, feedback_high_comparator};

  // Two-stage synchroniser; comparators switch with no regard to our clock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmp_meta <= '0;
      cmp <= '0;
    end else begin
      cmp_meta <= cmp_raw;
      cmp <= cmp_meta;
    end
  end

  assign fb_high = cmp[burst_restart_pkg::C_FB_HIGH];
  assign fb_low = cmp[burst_restart_pkg::C_FB_LOW];
  assign burst_up = cmp[burst_restart_pkg::C_BURST_UP];
  assign burst_lo = cmp[burst_restart_pkg::C_BURST_LO];
  assign sup_over = cmp[burst_restart_pkg::C_SUP_OVER];
  assign sup_ss = cmp[burst_restart_pkg::C_SUP_SS];
  assign sup_on = cmp[burst_restart_pkg::C_SUP_ON];
  assign sup_uv = cmp[burst_restart_pkg::C_SUP_UV];
  assign ba_high = cmp[burst_restart_pkg::C_PIN_HIGH];
  assign ba_low = cmp[burst_restart_pkg::C_PIN_LOW];
  assign hot = cmp[burst_restart_pkg::C_THERMAL];

  // Blanking timers, one per window
  genvar gi;
  generate
    for (gi = 0; gi < burst_restart_pkg::N_TIMERS; gi++) begin : g_timer
      blank_timer_if tif ();
      assign tif.run = trun[gi];
      assign tdone[gi] = tif.done;
      blank_timer #(
        .LIMIT(LIMITS[gi])
      ) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .tif(tif)
      );
    end
  endgenerate

  // Timer run conditions
  always_comb begin
    trun = '0;
    // Burst window only runs in normal operation, internal blanking only
    trun[burst_restart_pkg::T_BURST] = (state == burst_restart_pkg::ST_NORMAL)
      && fb_low;
    // Overload window runs on high feedback in normal operation only
    trun[burst_restart_pkg::T_LOAD] = (state == burst_restart_pkg::ST_NORMAL)
      && fb_high;
    trun[burst_restart_pkg::T_SPIKE] = restart_and_gate;
    // Supply overvoltage check is masked in burst
    trun[burst_restart_pkg::T_OVP] = is_operating(state) && sup_over
      && (state != burst_restart_pkg::ST_BURST);
    trun[burst_restart_pkg::T_IGN] = (state == burst_restart_pkg::ST_SOFT);
    trun[burst_restart_pkg::T_EXT] = is_operating(state) && ext_active;
  end

  // Pin clamp opens once overload blanking elapsed; pin then charges
  assign restart_and_gate = tdone[burst_restart_pkg::T_LOAD] && ba_high;

  // External request is blanked during the first part of start-up
  assign ext_active = ba_low && !((state == burst_restart_pkg::ST_SOFT)
    && !tdone[burst_restart_pkg::T_IGN]);

  assign soft_ovp = (state == burst_restart_pkg::ST_SOFT) && sup_ss && fb_high;

  // Faults that lead to restart; overload arrives only after its windows
  assign restart_req = hot
    || tdone[burst_restart_pkg::T_OVP]
    || tdone[burst_restart_pkg::T_SPIKE]
    || tdone[burst_restart_pkg::T_EXT]
    || soft_ovp;

  // Fault still present when start-up finishes
  assign fault_now = hot || ba_low || sup_over || fb_high;

  // Mode sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      burst_restart_pkg::ST_NORMAL: begin
        if (tdone[burst_restart_pkg::T_BURST] && fb_low) begin
          next_state = burst_restart_pkg::ST_BURST;
        end
      end
      burst_restart_pkg::ST_BURST: begin
        if (fb_high) begin
          next_state = burst_restart_pkg::ST_NORMAL;
        end
      end
      burst_restart_pkg::ST_RESTART: begin
        if (sup_uv) begin
          next_state = burst_restart_pkg::ST_CHARGE;
        end
      end
      burst_restart_pkg::ST_CHARGE: begin
        if (sup_on) begin
          next_state = burst_restart_pkg::ST_SOFT;
        end
      end
      burst_restart_pkg::ST_SOFT: begin
        if (soft_start_done) begin
          next_state = fault_now ? burst_restart_pkg::ST_RESTART
            : burst_restart_pkg::ST_NORMAL;
        end
      end
    endcase
    // Undervoltage goes straight to charging; others wait for supply to sag
    if (is_operating(state)) begin
      if (sup_uv) begin
        next_state = burst_restart_pkg::ST_CHARGE;
      end else if (restart_req) begin
        next_state = burst_restart_pkg::ST_RESTART;
      end
    end
  end

  // Power-on reset starts by charging the supply from the cell
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= burst_restart_pkg::ST_CHARGE;
    end else begin
      state <= next_state;
    end
  end

  // Burst bias hysteresis between the two burst levels
  assign burst_bias_gate = burst_flag && burst_lo && !burst_up;
  always_comb begin
    next_bias = 1'b0;
    if (next_state == burst_restart_pkg::ST_BURST) begin
      if (state != burst_restart_pkg::ST_BURST) begin
        next_bias = 1'b0;
      end else if (burst_up) begin
        next_bias = 1'b1;
      end else if (burst_bias_gate) begin
        next_bias = 1'b0;
      end else begin
        next_bias = bias_enable;
      end
    end else if (is_operating(next_state)) begin
      next_bias = 1'b1;
    end
  end

  assign reduced_limit_gate = (next_state == burst_restart_pkg::ST_BURST);

  // Registered outputs follow the next state so they line up with it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bias_enable <= 1'b0;
      reduced_limit_select <= 1'b0;
      burst_flag <= 1'b0;
    end else begin
      bias_enable <= next_bias;
      reduced_limit_select <= reduced_limit_gate;
      burst_flag <= (next_state == burst_restart_pkg::ST_BURST);
    end
  end

  // Gate, cell and clamp outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gate_enable <= 1'b0;
      startup_cell_on <= 1'b0;
      pin_clamp_switch <= 1'b1;
      in_soft_start <= 1'b0;
      in_restart <= 1'b0;
    end else begin
      // Request on the pin blocks gating at once, before restart is taken
      gate_enable <= is_operating(next_state) && next_bias && !ext_active;
      startup_cell_on <= (next_state == burst_restart_pkg::ST_CHARGE);
      pin_clamp_switch <= !tdone[burst_restart_pkg::T_LOAD];
      in_soft_start <= (next_state == burst_restart_pkg::ST_SOFT);
      in_restart <= (next_state == burst_restart_pkg::ST_RESTART)
        || (next_state == burst_restart_pkg::ST_CHARGE);
    end
  end

  burst_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == burst_restart_pkg::ST_NORMAL && tdone[burst_restart_pkg::T_BURST]
    && fb_low && !restart_req && !sup_uv |=> state == burst_restart_pkg::ST_BURST)
    else $error("burst not entered after blanking");

  burst_bias_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(burst_flag) |-> !bias_enable && !gate_enable)
    else $error("bias on at burst entry");

  burst_resume_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == burst_restart_pkg::ST_BURST && burst_up && !fb_high && !restart_req
    && !sup_uv |=> bias_enable)
    else $error("bias not resumed above upper level");

  burst_pause_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == burst_restart_pkg::ST_BURST && burst_lo && !burst_up && !fb_high
    |=> !bias_enable)
    else $error("bias not cut at lower level");

  reduced_limit_a: assert property (@(posedge clk) disable iff (!rst_n)
    reduced_limit_select == (state == burst_restart_pkg::ST_BURST))
    else $error("reduced limit mismatch with burst");

  burst_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == burst_restart_pkg::ST_BURST && fb_high |=> !reduced_limit_select)
    else $error("burst not left on high feedback");

  ovp_burst_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == burst_restart_pkg::ST_BURST |-> !trun[burst_restart_pkg::T_OVP])
    else $error("overvoltage check active in burst");

  thermal_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
    is_operating(state) && hot && !sup_uv |=> state == burst_restart_pkg::ST_RESTART)
    else $error("thermal fault not restarting");

  soft_ovp_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == burst_restart_pkg::ST_SOFT && sup_ss && fb_high && !sup_uv
    |=> state == burst_restart_pkg::ST_RESTART ##1 !gate_enable)
    else $error("soft start overvoltage not restarting");

  cell_charge_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == burst_restart_pkg::ST_RESTART && sup_uv |=> startup_cell_on
    && !gate_enable)
    else $error("startup cell not enabled at turn-off level");

  // Turn-on level ends charging and hands over to soft start
  cell_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == burst_restart_pkg::ST_CHARGE && sup_on
    |=> state == burst_restart_pkg::ST_SOFT && !startup_cell_on)
    else $error("startup cell not released at turn-on level");

  // Nothing may switch while waiting for the supply to sag
  restart_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == burst_restart_pkg::ST_RESTART |-> !gate_enable && !bias_enable)
    else $error("switching while in restart");

  // Fault still present at the end of start-up sends us back to restart
  recheck_fail_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == burst_restart_pkg::ST_SOFT && soft_start_done && fault_now && !sup_uv
    |=> state == burst_restart_pkg::ST_RESTART)
    else $error("persistent fault not caught at recheck");

  // Burst window must stay cleared outside normal operation
  burst_timer_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    state != burst_restart_pkg::ST_NORMAL |-> !trun[burst_restart_pkg::T_BURST])
    else $error("burst timer running outside normal");

  // Clamp opens on the edge after overload blanking completes
  clamp_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    tdone[burst_restart_pkg::T_LOAD] |=> !pin_clamp_switch)
    else $error("clamp not released after overload blanking");

  // Spike window elapsed with pin charged leads to restart
  spike_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
    is_operating(state) && tdone[burst_restart_pkg::T_SPIKE] && !sup_uv
    |=> state == burst_restart_pkg::ST_RESTART)
    else $error("overload not restarting after spike window");

  // Sustained supply overvoltage leads to restart
  ovp_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
    is_operating(state) && tdone[burst_restart_pkg::T_OVP] && !sup_uv
    |=> state == burst_restart_pkg::ST_RESTART)
    else $error("supply overvoltage not restarting");

  // An honoured pin request blocks gating at once
  ext_gate_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    ext_active |=> !gate_enable)
    else $error("gate still on under pin request");

  // Undervoltage turns off and charges from the cell
  uv_charge_a: assert property (@(posedge clk) disable iff (!rst_n)
    is_operating(state) && sup_uv
    |=> state == burst_restart_pkg::ST_CHARGE && startup_cell_on && !gate_enable)
    else $error("undervoltage not charging from cell");
endmodule : burst_restart_ctrl

/* File: comparator_model.sv */
`timescale 1ns/1ps
module comparator_model #(
  parameter int VCC_ON_MV = 18000,
  parameter int VCC_OFF_MV = 10500
) (
  // Analog levels in millivolts, temperature in degrees
  input wire logic signed [31:0] fb_mv,
  input wire logic signed [31:0] vcc_mv,
  input wire logic signed [31:0] pin_mv,
  input wire logic signed [31:0] temp_c,
  // Digitised comparator outputs
  output logic feedback_high_comparator,
  output logic feedback_low_comparator,
  output logic burst_upper_comparator,
  output logic burst_lower_comparator,
  output logic supply_over_comparator,
  output logic supply_soft_over,
  output logic supply_turn_on,
  output logic supply_under,
  output logic pin_high,
  output logic pin_low,
  output logic thermal_over
);
  // Feedback thresholds; levels change with no delay, so sync latency is the design's alone
  assign feedback_high_comparator = fb_mv > 4000;
  assign feedback_low_comparator = fb_mv < 1350;
  assign burst_upper_comparator = fb_mv > 3500;
  assign burst_lower_comparator = fb_mv <= 3000;
  // Supply thresholds; turn-on and turn-off levels are plain defaults
  assign supply_over_comparator = vcc_mv > 25500;
  assign supply_soft_over = vcc_mv > 20500;
  assign supply_turn_on = vcc_mv >= VCC_ON_MV;
  assign supply_under = vcc_mv < VCC_OFF_MV;
  // Blanking pin and thermal sense
  assign pin_high = pin_mv > 4000;
  assign pin_low = pin_mv < 330;
  assign thermal_over = temp_c > 130;
endmodule : comparator_model

/* File: test_burst_restart_ctrl.sv */
`timescale 1ns/1ps
module test_burst_restart_ctrl;
  localparam int BLANK = 50;
  localparam int IGN = 20;
  localparam int SPIKE = burst_restart_pkg::SPIKE_CYC;
  localparam int OVP = burst_restart_pkg::OVP_CYC;
  localparam int R = 0, B = 1, BI = 2, CL = 3, CE = 4, G = 5, S = 6;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic soft_start_done = 1'h0;
  int fb_mv = 2500, vcc_mv = 15000, pin_mv = 900, temp_c = 25;
  int error_cnt = 0, check_count = 0, cycles = 0, r;
  int fault_q[$] = '{0, 1, 2, 3};
  wire fbh, fbl, bup, blo, sov, ssov, son, sun, ph, pl, th;
  wire bias_enable, reduced_limit_select, gate_enable, startup_cell_on;
  wire pin_clamp_switch, burst_flag, in_soft_start, in_restart;
  wire [6:0] outs = {in_soft_start, gate_enable, startup_cell_on, pin_clamp_switch,
    bias_enable, burst_flag, in_restart};

  comparator_model comparator_model_inst (.fb_mv(fb_mv), .vcc_mv(vcc_mv), .pin_mv(pin_mv),
    .temp_c(temp_c), .feedback_high_comparator(fbh), .feedback_low_comparator(fbl),
    .burst_upper_comparator(bup), .burst_lower_comparator(blo), .supply_over_comparator(sov),
    .supply_soft_over(ssov), .supply_turn_on(son), .supply_under(sun), .pin_high(ph),
    .pin_low(pl), .thermal_over(th));

  burst_restart_ctrl #(.BLANK_CYCLES(BLANK), .IGNORE_CYCLES(IGN)) burst_restart_ctrl_inst (
    .clk(clk), .rst_n(rst_n), .feedback_high_comparator(fbh), .feedback_low_comparator(fbl),
    .burst_upper_comparator(bup), .burst_lower_comparator(blo), .supply_over_comparator(sov),
    .supply_soft_over(ssov), .supply_turn_on(son), .supply_under(sun), .pin_high(ph),
    .pin_low(pl), .thermal_over(th), .soft_start_done(soft_start_done),
    .bias_enable(bias_enable), .reduced_limit_select(reduced_limit_select),
    .gate_enable(gate_enable), .startup_cell_on(startup_cell_on),
    .pin_clamp_switch(pin_clamp_switch), .burst_flag(burst_flag),
    .in_soft_start(in_soft_start), .in_restart(in_restart));

  // Clock at 100 ns period
  always #50 clk = ~clk;

  // Hang guard, well above the few thousand cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic chk(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask : chk

  // Waits for one output to reach a level; the latency must fall in lo..hi cycles
  task automatic wait_out(input int k, input logic v, input int lo, input int hi,
    input string n);
    int c;
    c = 0;
    while (outs[k] !== v && c <= hi) begin
      @(negedge clk);
      c++;
    end
    check_count++;
    if (c < lo || c > hi) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0d..%0d cycles seen %0d", n, lo, hi, c);
    end
  endtask : wait_out

  // From restart (or charging) up to soft start
  task automatic go_soft(input logic from_charge);
    if (!from_charge) begin
      vcc_mv = 9000;
      wait_out(CE, 1'h1, 1, 8, "cell_on");
    end
    vcc_mv = 18000;
    wait_out(S, 1'h1, 1, 8, "soft_entry");
    chk("cell_off", 1'h0, startup_cell_on);
    chk("gate_soft", 1'h1, gate_enable);
  endtask : go_soft

  // Soft start ends with the fault gone: normal operation resumes
  task automatic finish_soft;
    soft_start_done = 1'h1;
    wait_out(S, 1'h0, 1, 8, "soft_exit");
    soft_start_done = 1'h0;
    chk("normal", 1'h0, in_restart);
  endtask : finish_soft

  task automatic wrap_up;
    if (error_cnt == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    r = $urandom(7189);
    repeat (10) @(negedge clk);
    rst_n = 1'h1;
    chk("clamp_rst", 1'h1, pin_clamp_switch);
    go_soft(1'h1);
    finish_soft();
    // Short dip below the low level must not enter burst
    fb_mv = 1000;
    repeat ($urandom_range(30, 10)) @(negedge clk);
    fb_mv = 2500;
    repeat (10) @(negedge clk);
    chk("no_burst", 1'h0, burst_flag);
    fb_mv = 1000;
    wait_out(B, 1'h1, BLANK, BLANK + 8, "burst_entry");
    chk("bias_off", 1'h0, bias_enable);
    chk("limit_sel", 1'h1, reduced_limit_select);
    // Overvoltage held well past its window is ignored while bursting
    vcc_mv = 26000;
    repeat (OVP + 100) @(negedge clk);
    chk("ovp_burst", 1'h0, in_restart);
    vcc_mv = 18000;
    fb_mv = 3600;
    wait_out(BI, 1'h1, 2, 6, "bias_up");
    chk("gate_up", 1'h1, gate_enable);
    fb_mv = 2900;
    wait_out(BI, 1'h0, 2, 6, "bias_down");
    chk("limit_hold", 1'h1, reduced_limit_select);
    fb_mv = 4100;
    wait_out(B, 1'h0, 2, 6, "burst_exit");
    chk("limit_full", 1'h0, reduced_limit_select);
    // Overload: clamp release, pin charge, spike delay, failed recheck
    wait_out(CL, 1'h0, BLANK, BLANK + 8, "clamp_release");
    chk("no_restart_yet", 1'h0, in_restart);
    pin_mv = 4100;
    wait_out(R, 1'h1, SPIKE, SPIKE + 8, "overload_restart");
    chk("gate_stop", 1'h0, gate_enable);
    go_soft(1'h0);
    soft_start_done = 1'h1;
    wait_out(R, 1'h1, 1, 8, "recheck_fault");
    soft_start_done = 1'h0;
    fb_mv = 2500;
    pin_mv = 900;
    go_soft(1'h0);
    finish_soft();
    // Direct faults: thermal, overvoltage, external request, undervoltage
    foreach (fault_q[i]) begin
      repeat ($urandom_range(20, 5)) @(negedge clk);
      case (fault_q[i])
        0: temp_c = 140;
        1: vcc_mv = 26000;
        2: pin_mv = 100;
        default: vcc_mv = 9000;
      endcase
      if (fault_q[i] == 2) wait_out(G, 1'h0, 2, 6, "gate_block");
      r = (fault_q[i] == 1) ? OVP : (fault_q[i] == 2) ? SPIKE : 2;
      wait_out((fault_q[i] == 3) ? CE : R, 1'h1, r, r + 8, "fault_entry");
      temp_c = 25;
      pin_mv = 900;
      if (fault_q[i] != 3) vcc_mv = 18000;
      go_soft(fault_q[i] == 3);
      finish_soft();
    end
    // Soft start: early external request ignored, then soft-start overvoltage
    temp_c = 140;
    wait_out(R, 1'h1, 2, 6, "thermal");
    temp_c = 25;
    go_soft(1'h0);
    pin_mv = 100;
    repeat (8) @(negedge clk);
    chk("pin_ignored", 1'h1, gate_enable);
    pin_mv = 900;
    vcc_mv = 21000;
    fb_mv = 4100;
    wait_out(R, 1'h1, 2, 6, "soft_ovp");
    vcc_mv = 18000;
    fb_mv = 2500;
    go_soft(1'h0);
    finish_soft();
    wrap_up();
  end
endmodule : test_burst_restart_ctrl
